/* rtl/odp_pkg.sv */
/*
  constants, state type and helper functions for the oscillator divider
  planner. assumes frequencies are integer hertz and a single host clock.
*/
package odp_pkg;

  // ****************************************
  // divider engine and frequency limits
  // ****************************************
  localparam int DW = 72; // width of the shared long divider
  localparam logic [35:0] FVCO_MIN_HZ = 36'h283baec00; // lowest vco
  localparam logic [35:0] FVCO_MAX_HZ = 36'h2d793bcd0; // slowest grade top
  localparam logic [35:0] XTAL_HZ = 36'h009187dc0; // crystal reference
  localparam logic [35:0] ADC_NOM_HZ = 36'h004c4b400; // nominal adc rate
  localparam logic [7:0] GAIN_SCALE = 8'h80; // gain scale factor
  localparam logic [3:0] ADC_PRE = 4'h8; // fixed adc prescale
  // scale * nominal rate * prescale, the gain numerator
  localparam logic [DW-1:0] GAIN_NUM =
    DW'(ADC_NOM_HZ) * DW'(GAIN_SCALE) * DW'(ADC_PRE);
  localparam int FRAC_W = 32; // feedback fraction width

  // ****************************************
  // output divider limits
  // ****************************************
  localparam logic [10:0] HS_MIN = 11'h004;
  localparam logic [10:0] HS_MAX = 11'h7fe;
  localparam logic [10:0] HS_ODD_MAX = 11'h021; // odd only up to here at low speed ratio one
  localparam logic [2:0] LS_EXP_MAX = 3'h5;

  // ****************************************
  // adc rate divider table
  // ****************************************
  localparam logic [10:0] NFX_T1 = 11'h048;
  localparam logic [10:0] NFX_T2 = 11'h04f;
  localparam logic [10:0] NFX_T3 = 11'h056;
  localparam logic [4:0] NFX_V0 = 5'h10;
  localparam logic [4:0] NFX_V1 = 5'h12;
  localparam logic [4:0] NFX_V2 = 5'h14;
  localparam logic [4:0] NFX_V3 = 5'h16;

  typedef enum logic [2:0] {
    S_IDLE, S_MIN, S_PICK, S_MUL, S_RNG, S_FB, S_GAIN
  } odp_state_e;

  // rate divider from the truncated feedback integer part
  function automatic logic [4:0] nfx_of(input logic [10:0] fi);
    if (fi < NFX_T1) return NFX_V0;
    else if (fi < NFX_T2) return NFX_V1;
    else if (fi < NFX_T3) return NFX_V2;
    else return NFX_V3;
  endfunction

  // ceiling of v / 2^e
  function automatic logic [35:0] ceil_shr(input logic [35:0] v,
                                           input logic [2:0] e);
    return (v + ((36'h1 << e) - 36'h1)) >> e;
  endfunction

endpackage

/* rtl/odp_planner.sv */
/*
  oscillator divider planner: from a centre output frequency works out
  the low and high speed dividers, the 11.32 feedback divider, the adc
  rate divider and the tuning adc full scale gain.
  assumes fout_hz_i and start_i come from logic on clock_i.
*/
// Notes on behaviour
// - vco equals fout times both output dividers
// - feedback divider is vco over crystal, centre
// - new vco always comes with new gain
// - gain is round of 128*80e6 over adc rate
// - rate divider 16/18/20/22 by feedback integer
// - feedback integer part truncated, not rounded
// - minimum total divider from lowest vco
// - smallest power-of-two low speed ratio that fits
// - nearest high speed divider, odd above 33 bumped at ratio one
// - recomputed vco must lie in range
// - low speed field is exponent, high speed binary
// - feedback in 11.32, fraction truncated
// - crystal reference divides the vco
// - high speed 4..2046, even above 33 at ratio one
`timescale 1ns/1ns
module odp_planner
  import odp_pkg::*;
#(
  parameter logic [35:0] FVCO_MAX = FVCO_MAX_HZ // top of the vco range
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i, // one-cycle request
  input wire logic [31:0] fout_hz_i, // wanted output frequency
  output logic busy_o,
  output logic done_o, // one-cycle pulse
  output logic error_o,
  output logic valid_o,
  output logic [2:0] low_speed_divider_o,
  output logic [10:0] high_speed_divider_o,
  output logic [10:0] feedback_integer_part_o,
  output logic [31:0] feedback_fraction_part_o,
  output logic [7:0] tuning_adc_full_scale_gain_o,
  output logic [4:0] adc_rate_divider_o,
  output logic [35:0] vco_hz_o
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // a top below the floor leaves no solution for any frequency
  if (FVCO_MAX <= FVCO_MIN_HZ) begin : g_bad_max
    $error("vco maximum must exceed the vco minimum");
  end

  // ****************************************
  // declarations
  // ****************************************
  odp_state_e state; // sequencer state
  logic [31:0] fout; // latched request
  logic [35:0] total; // minimum total output divider
  logic [2:0] exp; // low speed exponent under trial
  logic [10:0] hs_w; // chosen high speed divider
  logic [47:0] fvco; // recomputed vco
  logic [DW-1:0] d_rem, d_quo, d_den; // long divider state
  logic [6:0] d_cnt; // steps left
  logic d_fin; // quotient ready this cycle
  logic [DW-1:0] d_t, next_rem; // one restoring step
  logic d_ge;
  logic div_go; // load divider
  logic [DW-1:0] div_num, div_den;
  logic [35:0] hs_c; // candidate high speed ratio
  logic hs_fit;
  logic [10:0] hs_lo, hs_adj;
  logic in_range;
  logic [4:0] nfx_now;
  logic fail;

  assign busy_o = (state != S_IDLE);

  // ****************************************
  // shared restoring divider
  // ****************************************
  // one bit per cycle; a single engine serves all three divisions,
  // trading latency for area
  always_comb begin
    d_t = {d_rem[DW-2:0], d_quo[DW-1]};
    d_ge = (d_t >= d_den);
    next_rem = d_ge ? d_t - d_den : d_t;
  end

  // divider registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      d_rem <= '0;
      d_quo <= '0;
      d_den <= '0;
      d_cnt <= 7'h00;
      d_fin <= 1'b0;
    end else begin
      d_fin <= (d_cnt == 7'h01);
      if (div_go) begin
        d_quo <= div_num;
        d_den <= div_den;
        d_rem <= '0;
        d_cnt <= 7'(DW);
      end else if (d_cnt != 7'h00) begin
        d_rem <= next_rem;
        d_quo <= {d_quo[DW-2:0], d_ge};
        d_cnt <= d_cnt - 7'h01;
      end
    end
  end

  // ****************************************
  // divider selection
  // ****************************************
  // candidate ratio and its legal form for the exponent under trial
  always_comb begin
    hs_c = ceil_shr(total, exp);
    hs_fit = (hs_c <= 36'(HS_MAX));
    hs_lo = hs_c[10:0];
    if (hs_lo < HS_MIN) begin
      hs_adj = HS_MIN;
    end else if (exp == 3'h0 && hs_lo > HS_ODD_MAX && hs_lo[0]) begin
      hs_adj = hs_lo + 11'h001;
    end else begin
      hs_adj = hs_lo;
    end
  end

  // range check on the recomputed vco
  assign in_range = (fvco >= 48'(FVCO_MIN_HZ))
                 && (fvco <= 48'(FVCO_MAX));
  // truncated integer part picks the rate divider
  assign nfx_now = nfx_of(d_quo[FRAC_W+10:FRAC_W]);
  assign fail = (state == S_PICK && !hs_fit && exp == LS_EXP_MAX)
             || (state == S_RNG && !in_range);

  // divider launches: min total, feedback, gain
  always_comb begin
    div_go = 1'b0;
    div_num = '0;
    div_den = '0;
    case (state)
      S_IDLE: begin
        div_go = start_i && (fout_hz_i != 32'h0);
        div_num = DW'(FVCO_MIN_HZ);
        div_den = DW'(fout_hz_i);
      end
      S_RNG: begin
        div_go = in_range;
        div_num = DW'({fvco, 32'h0});
        div_den = DW'(XTAL_HZ);
      end
      S_FB: begin
        div_go = d_fin;
        // rounding: (2*num + vco) / (2*vco)
        div_num = DW'(GAIN_NUM * DW'(nfx_now) * DW'(2)) + DW'(fvco);
        div_den = DW'({fvco, 1'b0});
      end
      default: begin
        div_go = 1'b0;
      end
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  // requests while busy are ignored
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      fout <= 32'h0;
      total <= 36'h0;
      exp <= 3'h0;
      hs_w <= 11'h000;
      fvco <= 48'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_i) begin
            fout <= fout_hz_i;
            exp <= 3'h0;
            state <= (fout_hz_i == 32'h0) ? S_IDLE : S_MIN;
          end
        end
        S_MIN: begin
          if (d_fin) begin
            total <= d_quo[35:0] + {35'h0, |d_rem};
            state <= S_PICK;
          end
        end
        S_PICK: begin
          if (hs_fit) begin
            hs_w <= hs_adj;
            state <= S_MUL;
          end else if (exp == LS_EXP_MAX) begin
            state <= S_IDLE;
          end else begin
            exp <= exp + 3'h1;
          end
        end
        S_MUL: begin
          fvco <= (48'(fout) * 48'(hs_w)) << exp;
          state <= S_RNG;
        end
        S_RNG: begin
          state <= in_range ? S_FB : S_IDLE;
        end
        S_FB: begin
          if (d_fin) state <= S_GAIN;
        end
        S_GAIN: begin
          if (d_fin) state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // results
  // ****************************************
  // values are cleared at each request so a failed plan shows none
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      error_o <= 1'b0;
      valid_o <= 1'b0;
      low_speed_divider_o <= 3'h0;
      high_speed_divider_o <= 11'h000;
      feedback_integer_part_o <= 11'h000;
      feedback_fraction_part_o <= 32'h0;
      tuning_adc_full_scale_gain_o <= 8'h00;
      adc_rate_divider_o <= 5'h00;
      vco_hz_o <= 36'h0;
    end else begin
      done_o <= 1'b0;
      if (state == S_IDLE && start_i) begin
        error_o <= (fout_hz_i == 32'h0);
        done_o <= (fout_hz_i == 32'h0);
        valid_o <= 1'b0;
        low_speed_divider_o <= 3'h0;
        high_speed_divider_o <= 11'h000;
        feedback_integer_part_o <= 11'h000;
        feedback_fraction_part_o <= 32'h0;
        tuning_adc_full_scale_gain_o <= 8'h00;
        adc_rate_divider_o <= 5'h00;
        vco_hz_o <= 36'h0;
      end
      if (fail) begin
        error_o <= 1'b1;
        done_o <= 1'b1;
      end
      if (state == S_FB && d_fin) begin
        feedback_integer_part_o <= d_quo[FRAC_W+10:FRAC_W];
        feedback_fraction_part_o <= d_quo[FRAC_W-1:0];
        adc_rate_divider_o <= nfx_now;
      end
      if (state == S_GAIN && d_fin) begin
        tuning_adc_full_scale_gain_o <= d_quo[7:0];
        low_speed_divider_o <= exp;
        high_speed_divider_o <= hs_w;
        vco_hz_o <= fvco[35:0];
        valid_o <= 1'b1;
        done_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  logic ok; // finished with a plan
  logic [47:0] step; // vco step of one high speed count
  assign ok = done_o && !error_o;
  assign step = 48'(fout) << low_speed_divider_o;

  property p_vco_prod;
    ok |-> 48'(vco_hz_o) == 48'(high_speed_divider_o) * step;
  endproperty
  a_vco_prod: assert property (p_vco_prod) else $error("vco product");

  property p_fb_val;
    ok |-> DW'({feedback_integer_part_o, feedback_fraction_part_o})
      == DW'({vco_hz_o, 32'h0}) / DW'(XTAL_HZ);
  endproperty
  a_fb_val: assert property (p_fb_val) else $error("feedback value");

  property p_nfx;
    ok |-> adc_rate_divider_o == nfx_of(feedback_integer_part_o);
  endproperty
  a_nfx: assert property (p_nfx) else $error("rate divider");

  property p_hs_legal;
    ok |-> high_speed_divider_o >= HS_MIN && high_speed_divider_o <= HS_MAX
      && (low_speed_divider_o != 3'h0 || high_speed_divider_o <= HS_ODD_MAX
      || !high_speed_divider_o[0]);
  endproperty
  a_hs_legal: assert property (p_hs_legal) else $error("hs illegal");

  property p_vco_rng;
    ok |-> vco_hz_o >= FVCO_MIN_HZ && vco_hz_o <= FVCO_MAX;
  endproperty
  a_vco_rng: assert property (p_vco_rng) else $error("vco range");

  property p_nearest;
    ok && high_speed_divider_o > HS_MIN |->
      48'(vco_hz_o) < 48'(FVCO_MIN_HZ) + (step << 1);
  endproperty
  a_nearest: assert property (p_nearest) else $error("hs not nearest");

  property p_ls_small;
    ok && low_speed_divider_o != 3'h0 |->
      48'(HS_MAX) * (step >> 1) < 48'(FVCO_MIN_HZ);
  endproperty
  a_ls_small: assert property (p_ls_small) else $error("ls too big");

  property p_gain;
    ok |-> DW'(tuning_adc_full_scale_gain_o) * DW'({vco_hz_o, 1'b0})
      <= GAIN_NUM * DW'(adc_rate_divider_o) * DW'(2) + DW'(vco_hz_o);
  endproperty
  a_gain: assert property (p_gain) else $error("gain too large");

  property p_err_empty;
    done_o && error_o |-> !valid_o && vco_hz_o == 36'h0
      && high_speed_divider_o == 11'h000;
  endproperty
  a_err_empty: assert property (p_err_empty) else $error("err values");

  property p_finish;
    start_i && !busy_o |-> ##[1:300] done_o;
  endproperty
  a_finish: assert property (p_finish) else $error("no answer");

  c_plan: cover property (ok && low_speed_divider_o == 3'h0);
  c_ls: cover property (ok && low_speed_divider_o != 3'h0);
  c_odd: cover property (ok && high_speed_divider_o[0]);
  c_err: cover property (done_o && error_o);

endmodule

/* tb/odp_osc_model.sv */
/*
  behavioural model of the oscillator that takes the planned values.
  assumes the planner's outputs are settled whenever they are read.
*/
`timescale 1ns/1ns
module odp_osc_model
  import odp_pkg::*;
(
  input wire logic [2:0] low_speed_divider_i,
  input wire logic [10:0] high_speed_divider_i,
  input wire logic [10:0] feedback_integer_part_i,
  input wire logic [31:0] feedback_fraction_part_i,
  input wire logic [4:0] adc_rate_divider_i,
  output logic [63:0] vco_hz_o,
  output logic [63:0] out_hz_o,
  output logic [63:0] adc_hz_o
);
  logic [63:0] ls_ratio; // low speed ratio decoded from exponent
  logic [63:0] xtal; // crystal reference, widened

  // ****************************************
  // divider decode
  // ****************************************
  // exponents 5, 6 and 7 all mean the top ratio of 32
  always_comb begin
    ls_ratio = (low_speed_divider_i >= 3'h5) ? 64'h20 :
      (64'h1 << low_speed_divider_i);
    xtal = 64'(XTAL_HZ);
  end

  // ****************************************
  // frequencies
  // ****************************************
  // the decode does not depend on the speed grade
  always_comb begin
    vco_hz_o = xtal * 64'(feedback_integer_part_i) +
      ((xtal * 64'(feedback_fraction_part_i)) >> 32);
    // a zero divider appears from reset and from each request until a plan succeeds
    out_hz_o = (high_speed_divider_i == 11'h0) ? 64'h0 :
      vco_hz_o / (64'(high_speed_divider_i) * ls_ratio);
    // adc rate follows the vco through the rate divider
    adc_hz_o = (adc_rate_divider_i == 5'h0) ? 64'h0 :
      vco_hz_o / 64'(adc_rate_divider_i) / 64'h8;
  end
endmodule

/* tb/odp_planner_bench.sv */
/*
  bench for odp_planner: plans a table of frequencies on a slow grade and
  a fast grade instance, compares with a reference and the oscillator.
  assumes the plan holds from done until the next taken start.
*/
`timescale 1ns/1ns
module odp_planner_bench;
  import odp_pkg::*;
  typedef struct packed {
    logic err; logic [2:0] ls; logic [10:0] hs; logic [10:0] fi;
    logic [31:0] fr; logic [7:0] g; logic [4:0] nx; logic [35:0] vco;
  } odp_exp_s;
  localparam logic [35:0] FAST_MAX = 36'h30e2537c6; // fastest grade top
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [31:0] fout_hz_i = 32'h0;
  logic busy_a, done_a, err_a, val_a, busy_b, done_b, err_b, val_b;
  logic [2:0] ls_a, ls_b;
  logic [10:0] hs_a, hs_b, fi_a, fi_b;
  logic [31:0] fr_a, fr_b;
  logic [7:0] g_a, g_b;
  logic [4:0] nx_a, nx_b;
  logic [35:0] vco_a, vco_b;
  logic [63:0] m_vco, m_out, m_adc;
  logic [31:0] freqs [13] = '{32'h0957d0b0, 32'h13c9eb00, 32'hb2d05e00,
    32'hb4018b00, 32'h9502f900, 32'hee6b2800, 32'h004c4b40, 32'h002625a0,
    32'h000f4240, 32'h00061a80, 32'h00030d40, 32'h000249f0, 32'h0};
  int mismatches = 0;
  int tests_run = 0;

  always #4 clock_i = ~clock_i;

  odp_planner dut (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i),
    .fout_hz_i(fout_hz_i), .busy_o(busy_a), .done_o(done_a),
    .error_o(err_a), .valid_o(val_a), .low_speed_divider_o(ls_a),
    .high_speed_divider_o(hs_a), .feedback_integer_part_o(fi_a),
    .feedback_fraction_part_o(fr_a), .tuning_adc_full_scale_gain_o(g_a),
    .adc_rate_divider_o(nx_a), .vco_hz_o(vco_a));
  odp_planner #(.FVCO_MAX(FAST_MAX)) dut_fast (.clock_i(clock_i),
    .rst_i(rst_i), .start_i(start_i), .fout_hz_i(fout_hz_i),
    .busy_o(busy_b), .done_o(done_b), .error_o(err_b), .valid_o(val_b),
    .low_speed_divider_o(ls_b), .high_speed_divider_o(hs_b),
    .feedback_integer_part_o(fi_b), .feedback_fraction_part_o(fr_b),
    .tuning_adc_full_scale_gain_o(g_b), .adc_rate_divider_o(nx_b),
    .vco_hz_o(vco_b));
  odp_osc_model model (.low_speed_divider_i(ls_a),
    .high_speed_divider_i(hs_a), .feedback_integer_part_i(fi_a),
    .feedback_fraction_part_i(fr_a), .adc_rate_divider_i(nx_a),
    .vco_hz_o(m_vco), .out_hz_o(m_out), .adc_hz_o(m_adc));

  // ****************************************
  // comparison, reference and verdict
  // ****************************************
  task automatic check(input string name, input logic [127:0] exp,
                       input logic [127:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // integer form of the planning steps; error leaves all values zero
  function automatic odp_exp_s ref_plan(input logic [31:0] f,
                                        input logic [35:0] vmax);
    odp_exp_s r;
    longint fl, hs, vco, nx;
    int e;
    r = '0;
    r.err = 1'b1;
    fl = longint'(f);
    e = 0;
    if (f == 32'h0) return r;
    hs = (longint'(FVCO_MIN_HZ) + fl - 1) / fl;
    while (e < 5 && hs > 11'h7fe) begin
      e++;
      hs = (longint'(FVCO_MIN_HZ) + (fl << e) - 1) / (fl << e);
    end
    if (hs > 11'h7fe) return r;
    if (e == 0 && hs > 6'h21 && hs[0]) hs++;
    if (hs < 4'h4) hs = 4'h4;
    vco = (fl * hs) << e;
    if (vco > longint'(vmax)) return r;
    nx = vco / longint'(XTAL_HZ);
    r.fr = 32'(((vco % longint'(XTAL_HZ)) << 32) / longint'(XTAL_HZ));
    r.err = 1'b0;
    r.ls = 3'(e);
    r.hs = 11'(hs);
    r.fi = 11'(nx);
    r.vco = 36'(vco);
    nx = nx < 72 ? 16 : nx < 79 ? 18 : nx < 86 ? 20 : 22;
    r.nx = 5'(nx);
    r.g = 8'((2 * longint'(GAIN_NUM) * nx / vco + 1) / 2);
    return r;
  endfunction

  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one plan on both instances; f_late is a start sent while busy
  task automatic plan(input logic [31:0] f, input logic [31:0] f_late);
    odp_exp_s ra, rb;
    int n, na, nb;
    ra = ref_plan(f, FVCO_MAX_HZ);
    rb = ref_plan(f, FAST_MAX);
    @(posedge clock_i) #1;
    start_i = 1'b1;
    fout_hz_i = f;
    n = 0;
    na = 0;
    nb = 0;
    while (n < 400 && (na == 0 || nb == 0)) begin
      @(posedge clock_i) #1;
      n++;
      start_i = (n == 4 && f_late != 32'h0);
      fout_hz_i = start_i ? f_late : f;
      if (n == 2 && f != 32'h0) check("busy", 1, busy_a);
      if (done_a === 1'b1) na = n;
      if (done_b === 1'b1) nb = n;
    end
    @(posedge clock_i) #1;
    check("done pulse", 0, {done_a, done_b});
    if (!ra.err) check("latency", 222 + ra.ls, na - 1);
    check("plan a", ra, {err_a, ls_a, hs_a, fi_a, fr_a, g_a, nx_a,
      vco_a});
    check("valid a", !ra.err, val_a);
    check("plan b", rb, {err_b, ls_b, hs_b, fi_b, fr_b, g_b, nx_b,
      vco_b});
    check("valid b", !rb.err, val_b);
    if (!ra.err) check("model vco", 1, (64'(ra.vco) - m_vco) <= 64'h1);
    if (!ra.err) check("model out", 1, (64'(f) - m_out) <= 64'h1);
    // the gain times the oscillator's own adc rate lands near the target
    if (!ra.err) check("model adc", 1,
      64'(g_a) * m_adc + m_adc >= 64'(GAIN_SCALE) * 64'(ADC_NOM_HZ) &&
      64'(g_a) * m_adc <= 64'(GAIN_SCALE) * 64'(ADC_NOM_HZ) + m_adc);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    check("reset", 0, {busy_a, done_a, val_a, err_a, vco_a, fr_a});
    foreach (freqs[i]) plan(freqs[i], 32'h0);
    plan(32'h0957d0b0, 32'h05f5e100);
    // worked values for 156.75 MHz, held until the next taken start
    check("walk", {11'h046, 11'h047, 32'he756e62a, 8'h77},
      {hs_a, fi_a, fr_a, g_a});
    // a reset in mid plan must clear everything
    @(posedge clock_i) #1;
    start_i = 1'b1;
    fout_hz_i = 32'h05f5e100;
    @(posedge clock_i) #1;
    start_i = 1'b0;
    repeat (20) @(posedge clock_i);
    #1;
    rst_i = 1'b1;
    @(posedge clock_i) #1;
    rst_i = 1'b0;
    check("mid reset", 0, {busy_a, done_a, val_a, vco_a, fr_a, g_a});
    plan(32'h05f5e100, 32'h0);
    report_and_stop();
  end

  // cut a hang short; the tests need about 23 us
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
endmodule
